/* File: hw/audio_dec_regs.sv */
// Purpose: special-function register bank of the hardwired audio decoder
// Assumes: core strobes sfr_rd_i/sfr_wr_i for one cycle; decoder on same clock
// Notes: read data appears one cycle after the read strobe
`timescale 1ns/100ps

module audio_dec_regs #(
  parameter int FILL_BYTES = audio_dec_regs_pkg::FIRST_FILL_BYTES,
  parameter int AUX_DEPTH = audio_dec_regs_pkg::AUX_DEPTH
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // special-function register port
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  // interrupt enables and request
  input wire logic decoder_irq_enable_i,
  input wire logic global_irq_enable_i,
  output logic decoder_irq_o,
  // decoder events and header
  input wire logic dec_need_data_i,
  input wire logic layer_err_i,
  input wire logic sync_err_i,
  input wire logic crc_err_i,
  input wire logic hdr_valid_i,
  input wire logic hdr_version_one_i,
  input wire logic [1:0] hdr_rate_sel_i,
  // ancillary data from decoder
  input wire logic aux_push_i,
  input wire logic [7:0] aux_push_data_i,
  output logic aux_room_o,
  // controls to decoder
  output logic decoder_on_o,
  output logic low_boost_on_o,
  output logic play_bad_checksum_o,
  output logic [4:0] left_volume_o,
  output logic frame_skip_o,
  output logic first_fill_o,
  // stream bytes to decoder
  output logic [7:0] stream_byte_o,
  output logic stream_valid_o
);

  localparam int CW = $clog2(FILL_BYTES);

  typedef audio_dec_regs_pkg::fill_state_e fill_state_e;

  logic [7:0] control;
  logic [4:0] left_volume;
  logic version_one;
  logic [1:0] rate_sel;
  logic frame_wanted;
  logic byte_wanted;
  logic reset_mark;
  logic request;
  logic request_q;
  logic [CW-1:0] fill_count;
  fill_state_e state;
  logic aux_avail;
  logic aux_empty;
  logic aux_full;
  logic [7:0] aux_head;
  logic [3:0] err_flags;
  logic [3:0] err_set;
  logic status_read;
  logic stream_wr;
  logic aux_read;
  logic [4:0] irq_src;
  logic [7:0] next_rdata;

  assign status_read = sfr_rd_i && (sfr_addr_i == audio_dec_regs_pkg::ADDR_STATUS);
  assign stream_wr = sfr_wr_i && (sfr_addr_i == audio_dec_regs_pkg::ADDR_STREAM_INPUT);
  assign aux_read = sfr_rd_i && (sfr_addr_i == audio_dec_regs_pkg::ADDR_AUX_BYTE);

  ////////////////////////////////////////////////////////////////////////////////
  // control and volume registers

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      control <= audio_dec_regs_pkg::CONTROL_RESET;
    end
    else if (sfr_wr_i && (sfr_addr_i == audio_dec_regs_pkg::ADDR_CONTROL))
    begin
      control <= sfr_wdata_i;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      left_volume <= audio_dec_regs_pkg::LEFT_VOLUME_RESET;
    end
    else if (sfr_wr_i && (sfr_addr_i == audio_dec_regs_pkg::ADDR_LEFT_VOLUME))
    begin
      // upper bits are reserved and never stored
      left_volume <= sfr_wdata_i[audio_dec_regs_pkg::VOLUME_BITS-1:0];
    end
  end

  assign decoder_on_o = control[audio_dec_regs_pkg::CTL_DECODER_ON];
  assign low_boost_on_o = control[audio_dec_regs_pkg::CTL_LOW_BOOST_ON];
  assign play_bad_checksum_o = control[audio_dec_regs_pkg::CTL_PLAY_BAD_CHECKSUM];
  assign left_volume_o = left_volume;

  // bad-checksum frame is dropped only when playing it is not allowed
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      frame_skip_o <= 1'b0;
    end
    else
    begin
      frame_skip_o <= crc_err_i && decoder_on_o && !play_bad_checksum_o;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // initial fill sequencing and request generation

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      state <= audio_dec_regs_pkg::ST_OFF;
      fill_count <= '0;
    end
    else if (!decoder_on_o)
    begin
      state <= audio_dec_regs_pkg::ST_OFF;
      fill_count <= '0;
    end
    else
    begin
      unique case (state)
        audio_dec_regs_pkg::ST_OFF:
        begin
          state <= audio_dec_regs_pkg::ST_FILL;
          fill_count <= '0;
        end
        audio_dec_regs_pkg::ST_FILL:
        begin
          if (stream_wr)
          begin
            fill_count <= fill_count + 1'b1;
            if (fill_count == CW'(FILL_BYTES - 1))
            begin
              state <= audio_dec_regs_pkg::ST_RUN;
            end
          end
        end
        audio_dec_regs_pkg::ST_RUN:
        begin
          state <= audio_dec_regs_pkg::ST_RUN;
        end
        default:
        begin
          state <= audio_dec_regs_pkg::ST_OFF;
        end
      endcase
    end
  end

  // the whole initial fill is one request, whatever the decoder says
  assign request = (state == audio_dec_regs_pkg::ST_FILL)
                || ((state == audio_dec_regs_pkg::ST_RUN) && dec_need_data_i);

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      request_q <= 1'b0;
      first_fill_o <= 1'b0;
    end
    else
    begin
      request_q <= request;
      first_fill_o <= (state == audio_dec_regs_pkg::ST_FILL);
    end
  end

  // frame_wanted holds its reset value until the decoder is first enabled
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      frame_wanted <= 1'b1;
      reset_mark <= 1'b1;
    end
    else if (decoder_on_o)
    begin
      frame_wanted <= request;
      reset_mark <= 1'b0;
    end
  end

  // byte request drops for the cycle after each write and returns while requested
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      byte_wanted <= 1'b0;
    end
    else
    begin
      byte_wanted <= request && !stream_wr;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      stream_byte_o <= 8'h00;
      stream_valid_o <= 1'b0;
    end
    else
    begin
      stream_valid_o <= stream_wr;
      if (stream_wr)
      begin
        stream_byte_o <= sfr_wdata_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // status flags and frame information

  // order: need_input, bad_layer, lost_sync, bad_checksum
  assign err_set = {request && !request_q, layer_err_i, sync_err_i, crc_err_i};

  generate
    for (genvar i = 0; i < 4; i++)
    begin : g_flag
      sticky_flag #(
        .RESET_VAL(1'b0)
      ) u_flag (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .set_i(err_set[i]),
        .clr_i(status_read),
        .flag_o(err_flags[i])
      );
    end
  endgenerate

  // header fields change only from the decoder; core writes never reach them
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      version_one <= audio_dec_regs_pkg::STATUS_RESET[audio_dec_regs_pkg::STA_VERSION_ONE];
      rate_sel <= 2'h0;
    end
    else if (hdr_valid_i)
    begin
      version_one <= hdr_version_one_i;
      rate_sel <= hdr_rate_sel_i;
    end
  end

  aux_byte_fifo #(
    .WIDTH(audio_dec_regs_pkg::BYTE_BITS),
    .DEPTH(AUX_DEPTH)
  ) u_aux (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .push_i(aux_push_i),
    .push_data_i(aux_push_data_i),
    .full_o(aux_full),
    .pop_i(aux_read),
    .head_o(aux_head),
    .empty_o(aux_empty)
  );

  assign aux_avail = !aux_empty;

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      aux_room_o <= 1'b1;
    end
    else
    begin
      // conservative: no room shown while a push is in flight, so a decoder
      // pushing back to back is held to every other cycle
      aux_room_o <= !aux_full && !aux_push_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt and read mux

  assign irq_src = {aux_avail, err_flags} & ~control[4:0];

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      decoder_irq_o <= 1'b0;
    end
    else
    begin
      decoder_irq_o <= (|irq_src) && decoder_irq_enable_i && global_irq_enable_i;
    end
  end

  always_comb
  begin
    next_rdata = 8'h00;
    unique case (sfr_addr_i)
      audio_dec_regs_pkg::ADDR_CONTROL: next_rdata = control;
      audio_dec_regs_pkg::ADDR_LEFT_VOLUME: next_rdata = {3'h0, left_volume};
      audio_dec_regs_pkg::ADDR_AUX_BYTE: next_rdata = aux_empty ? 8'h00 : aux_head;
      audio_dec_regs_pkg::ADDR_STATUS: next_rdata = {aux_avail, err_flags, rate_sel, version_one};
      audio_dec_regs_pkg::ADDR_REQUEST_STATUS:
        next_rdata = {3'h0, frame_wanted, byte_wanted, 2'h0, reset_mark};
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      sfr_rdata_o <= 8'h00;
    end
    else if (sfr_rd_i)
    begin
      sfr_rdata_o <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_status_read;
    sfr_rd_i && (sfr_addr_i == audio_dec_regs_pkg::ADDR_STATUS);
  endsequence

  sequence s_stream_write;
    sfr_wr_i && (sfr_addr_i == audio_dec_regs_pkg::ADDR_STREAM_INPUT);
  endsequence

  sequence s_fill_last;
    (state == audio_dec_regs_pkg::ST_FILL) && stream_wr && decoder_on_o
      && (fill_count == CW'(FILL_BYTES - 1));
  endsequence

  chk_control_reset: assert property (@(posedge mclk_i) reset_i |=>
    control == audio_dec_regs_pkg::CONTROL_RESET)
    else $error("control register not at reset value");

  chk_read_clears: assert property (@(posedge mclk_i) disable iff (reset_i)
    s_status_read ##0 !layer_err_i |=> !err_flags[2])
    else $error("bad_layer survived a status read");

  chk_set_wins: assert property (@(posedge mclk_i) disable iff (reset_i)
    crc_err_i |=> err_flags[0])
    else $error("checksum error lost");

  chk_byte_clear: assert property (@(posedge mclk_i) disable iff (reset_i)
    s_stream_write |=> !byte_wanted)
    else $error("byte_wanted not cleared by stream write");

  chk_irq_gate: assert property (@(posedge mclk_i) disable iff (reset_i)
    decoder_irq_o |-> $past(decoder_irq_enable_i && global_irq_enable_i))
    else $error("interrupt raised without both enables");

  chk_irq_masked: assert property (@(posedge mclk_i) disable iff (reset_i)
    (control[4:0] == 5'h1F) |=> !decoder_irq_o)
    else $error("interrupt raised with all sources masked");

  chk_aux_flag: assert property (@(posedge mclk_i) disable iff (reset_i)
    aux_push_i |=> aux_avail)
    else $error("aux_avail not set after ancillary push");

  chk_fill_end: assert property (@(posedge mclk_i) disable iff (reset_i)
    s_fill_last |=> (state == audio_dec_regs_pkg::ST_RUN))
    else $error("initial fill did not end after its last byte");

  chk_fill_frame: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state == audio_dec_regs_pkg::ST_FILL) [*2] |-> frame_wanted)
    else $error("frame_wanted low during initial fill");

  chk_status_ro: assert property (@(posedge mclk_i) disable iff (reset_i)
    sfr_wr_i && (sfr_addr_i == audio_dec_regs_pkg::ADDR_STATUS) && !hdr_valid_i
      |=> $stable(version_one) && $stable(rate_sel))
    else $error("status register changed by a core write");

  chk_skip_frame: assert property (@(posedge mclk_i) disable iff (reset_i)
    crc_err_i && decoder_on_o |=> (frame_skip_o == !$past(play_bad_checksum_o)))
    else $error("bad-checksum frame handling wrong");

endmodule : audio_dec_regs

/* File: hw/audio_dec_regs_pkg.sv */
// Purpose: constants for the audio decoder special-function register bank
// Assumes: 8-bit core bus, one clock, synchronous active-high reset
// Notes: shared by the register bank and its testbench

package audio_dec_regs_pkg;

  // register addresses
  localparam logic [7:0] ADDR_LEFT_VOLUME = 8'h9E;
  localparam logic [7:0] ADDR_CONTROL = 8'hAA;
  localparam logic [7:0] ADDR_STREAM_INPUT = 8'hAC;
  localparam logic [7:0] ADDR_AUX_BYTE = 8'hAD;
  localparam logic [7:0] ADDR_REQUEST_STATUS = 8'hAF;
  localparam logic [7:0] ADDR_STATUS = 8'hC8;

  // reset values
  localparam logic [7:0] CONTROL_RESET = 8'h3F;
  localparam logic [7:0] STATUS_RESET = 8'h01;
  localparam logic [7:0] REQUEST_STATUS_RESET = 8'h11;
  localparam logic [4:0] LEFT_VOLUME_RESET = 5'h00;

  // control fields
  localparam int CTL_DECODER_ON = 7;
  localparam int CTL_LOW_BOOST_ON = 6;
  localparam int CTL_PLAY_BAD_CHECKSUM = 5;
  localparam int CTL_MASK_HI = 4;
  localparam int CTL_MASK_LO = 0;

  // status fields
  localparam int STA_AUX_AVAIL = 7;
  localparam int STA_NEED_INPUT = 6;
  localparam int STA_BAD_LAYER = 5;
  localparam int STA_LOST_SYNC = 4;
  localparam int STA_BAD_CHECKSUM = 3;
  localparam int STA_RATE_HI = 2;
  localparam int STA_RATE_LO = 1;
  localparam int STA_VERSION_ONE = 0;

  // request status fields
  localparam int REQ_FRAME_WANTED = 4;
  localparam int REQ_BYTE_WANTED = 3;
  localparam int REQ_RESET_MARK = 0;
  localparam int VOLUME_BITS = 5;

  // sample-rate codes, read together with the version bit
  localparam logic [1:0] RATE_CODE_A = 2'h0; // 44.1 kHz (I), 22.05 kHz (II)
  localparam logic [1:0] RATE_CODE_B = 2'h1; // 48 kHz (I), 24 kHz (II)
  localparam logic [1:0] RATE_CODE_C = 2'h2; // 32 kHz (I), 16 kHz (II)
  localparam logic [1:0] RATE_CODE_RSVD = 2'h3;

  // initial fill and ancillary buffer
  localparam int FIRST_FILL_BYTES = 1024;
  localparam int AUX_DEPTH = 16;
  localparam int BYTE_BITS = 8;

  // interrupt source order, bit 4 down to 0
  localparam int IRQ_SOURCES = 5;

  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_FILL = 3'b010,
    ST_RUN = 3'b100
  } fill_state_e;

endpackage : audio_dec_regs_pkg

/* File: hw/sticky_flag.sv */
// Purpose: one hardware-set, read-cleared status flag
// Assumes: set and clear are single-cycle strobes on the same clock
// Notes: a set in the clearing cycle wins so no event is lost
`timescale 1ns/100ps

module sticky_flag #(
  parameter logic RESET_VAL = 1'b0
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // control
  input wire logic set_i,
  input wire logic clr_i,
  // state
  output logic flag_o
);

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      flag_o <= RESET_VAL;
    end
    else if (set_i)
    begin
      flag_o <= 1'b1;
    end
    else if (clr_i)
    begin
      flag_o <= 1'b0;
    end
  end

endmodule : sticky_flag

/* File: hw/aux_byte_fifo.sv */
// Purpose: ancillary data byte buffer between decoder and core
// Assumes: push and pop are single-cycle strobes
// Notes: push while full is dropped; pop while empty is ignored
`timescale 1ns/100ps

module aux_byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // fill side
  input wire logic push_i,
  input wire logic [WIDTH-1:0] push_data_i,
  output logic full_o,
  // drain side
  input wire logic pop_i,
  output logic [WIDTH-1:0] head_o,
  output logic empty_o
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic do_push;
  logic do_pop;

  assign full_o = (count == (AW+1)'(DEPTH));
  assign empty_o = (count == '0);
  assign do_push = push_i && !full_o;
  assign do_pop = pop_i && !empty_o;
  assign head_o = mem[rd_ptr];

  always_ff @(posedge mclk_i)
  begin
    if (do_push)
    begin
      mem[wr_ptr] <= push_data_i;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (do_push)
      begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_pop)
      begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

endmodule : aux_byte_fifo

/* File: verif/decoder_model.sv */
// Purpose: behavioural stand-in for the decoder core behind the register bank
// Assumes: all outputs change on the falling edge, one event per task call
// Notes: released data lines show the inverse of their last value
`timescale 1ns/100ps

module decoder_model (
  // clock
  input wire logic mclk_i,
  // flow control from the bank
  input wire logic aux_room_i,
  // decoder events
  output logic dec_need_data_o,
  output logic layer_err_o,
  output logic sync_err_o,
  output logic crc_err_o,
  // frame header
  output logic hdr_valid_o,
  output logic hdr_version_one_o,
  output logic [1:0] hdr_rate_sel_o,
  // ancillary bytes
  output logic aux_push_o,
  output logic [7:0] aux_push_data_o
);
  initial
  begin
    dec_need_data_o = 1'b0;
    {layer_err_o, sync_err_o, crc_err_o, hdr_valid_o, aux_push_o} = 5'h00;
    hdr_version_one_o = 1'b1;
    hdr_rate_sel_o = 2'h0;
    aux_push_data_o = 8'h00;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic pulse_err(input int k);
    @(negedge mclk_i);
    layer_err_o = (k == 0);
    sync_err_o = (k == 1);
    crc_err_o = (k == 2);
    @(negedge mclk_i);
    {layer_err_o, sync_err_o, crc_err_o} = 3'h0;
  endtask : pulse_err

  task automatic header(input logic ver, input logic [1:0] rate);
    @(negedge mclk_i);
    hdr_valid_o = 1'b1;
    hdr_version_one_o = ver;
    hdr_rate_sel_o = rate;
    @(negedge mclk_i);
    hdr_valid_o = 1'b0;
    hdr_version_one_o = ~ver;
    hdr_rate_sel_o = ~rate;
  endtask : header

  // a full buffer would drop the byte, so wait for room first
  task automatic push_aux(input logic [7:0] d);
    @(negedge mclk_i);
    for (int w = 0; w < 16 && !aux_room_i; w++)
    begin
      @(negedge mclk_i);
    end
    if (aux_room_i)
    begin
      aux_push_o = 1'b1;
      aux_push_data_o = d;
      @(negedge mclk_i);
      aux_push_o = 1'b0;
      aux_push_data_o = ~d;
    end
  endtask : push_aux

  task automatic set_need(input logic b);
    @(negedge mclk_i);
    dec_need_data_o = b;
  endtask : set_need
endmodule : decoder_model

/* File: verif/audio_dec_regs_test.sv */
// Purpose: self-checking bench for the audio decoder register bank
// Assumes: fill count shortened to 8 bytes
// Notes: core accesses are one-cycle strobes launched on the falling edge
`timescale 1ns/100ps

`define CHK(nm, e, g) \
  begin \
    cmp_count++; \
    if ((g) !== (e)) \
    begin \
      fails++; \
      $display("Error %s expected %h seen %h", nm, e, g); \
    end \
  end

module audio_dec_regs_test;
  localparam int FILL = 8;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] sfr_addr_i = 8'h00;
  logic sfr_wr_i = 1'b0;
  logic sfr_rd_i = 1'b0;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic [7:0] sfr_rdata_o;
  logic decoder_irq_enable_i = 1'b1;
  logic global_irq_enable_i = 1'b1;
  logic decoder_irq_o, dec_need_data_i, layer_err_i, sync_err_i, crc_err_i;
  logic hdr_valid_i, hdr_version_one_i, aux_push_i, aux_room_o, first_fill_o;
  logic [1:0] hdr_rate_sel_i;
  logic [7:0] aux_push_data_i, stream_byte_o, rd;
  logic decoder_on_o, low_boost_on_o, play_bad_checksum_o, frame_skip_o, stream_valid_o;
  logic [4:0] left_volume_o;
  int fails = 0;
  int cmp_count = 0;

  always #25 mclk_i = ~mclk_i;

  audio_dec_regs #(.FILL_BYTES(FILL)) i_dut (.mclk_i(mclk_i), .reset_i(reset_i),
    .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
    .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
    .decoder_irq_enable_i(decoder_irq_enable_i), .global_irq_enable_i(global_irq_enable_i),
    .decoder_irq_o(decoder_irq_o), .dec_need_data_i(dec_need_data_i),
    .layer_err_i(layer_err_i), .sync_err_i(sync_err_i), .crc_err_i(crc_err_i),
    .hdr_valid_i(hdr_valid_i), .hdr_version_one_i(hdr_version_one_i),
    .hdr_rate_sel_i(hdr_rate_sel_i), .aux_push_i(aux_push_i),
    .aux_push_data_i(aux_push_data_i), .aux_room_o(aux_room_o),
    .decoder_on_o(decoder_on_o), .low_boost_on_o(low_boost_on_o),
    .play_bad_checksum_o(play_bad_checksum_o), .left_volume_o(left_volume_o),
    .frame_skip_o(frame_skip_o), .first_fill_o(first_fill_o), .stream_byte_o(stream_byte_o),
    .stream_valid_o(stream_valid_o));

  decoder_model i_dec (.mclk_i(mclk_i), .aux_room_i(aux_room_o),
    .dec_need_data_o(dec_need_data_i), .layer_err_o(layer_err_i),
    .sync_err_o(sync_err_i), .crc_err_o(crc_err_i), .hdr_valid_o(hdr_valid_i),
    .hdr_version_one_o(hdr_version_one_i), .hdr_rate_sel_o(hdr_rate_sel_i),
    .aux_push_o(aux_push_i), .aux_push_data_o(aux_push_data_i));

  //////////////////////////////////////////////////////////////////////////////
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    @(negedge mclk_i);
    sfr_wr_i = 1'b0;
  endtask : sfr_write

  // read data lands on the edge that takes the strobe
  task automatic chk_reg(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(negedge mclk_i);
    sfr_addr_i = a;
    sfr_rd_i = 1'b1;
    @(negedge mclk_i);
    sfr_rd_i = 1'b0;
    rd = sfr_rdata_o;
    `CHK($sformatf("register %h", a), e, rd & m)
  endtask : chk_reg

  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results

  initial
  begin
    #(5000 * 50);
    fails++;
    results();
  end

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(negedge mclk_i);
    reset_i = 1'b0;
    chk_reg(8'hAA, 8'hFF, 8'h3F);
    chk_reg(8'hC8, 8'hFF, 8'h01);
    chk_reg(8'hAF, 8'hFF, 8'h11);
    chk_reg(8'hAD, 8'hFF, 8'h00);
    chk_reg(8'h90, 8'hFF, 8'h00);
    sfr_write(8'hC8, 8'hFE);
    chk_reg(8'hC8, 8'hFF, 8'h01);
    sfr_write(8'h9E, 8'h15);
    chk_reg(8'h9E, 8'hFF, 8'h15);
    `CHK("left volume", 5'h15, left_volume_o)
    $display("test reset and map done");
    for (int k = 0; k < 3; k++)
    begin
      sfr_write(8'hAA, 8'h3F);
      i_dec.pulse_err(k);
      repeat (2) @(negedge mclk_i);
      `CHK("masked irq", 1'b0, decoder_irq_o)
      chk_reg(8'hC8, 8'h38, 8'h20 >> k);
      chk_reg(8'hC8, 8'h38, 8'h00);
      sfr_write(8'hAA, 8'h20 | (8'h1F & ~(8'h04 >> k)));
      i_dec.pulse_err(k);
      repeat (2) @(negedge mclk_i);
      `CHK("unmasked irq", 1'b1, decoder_irq_o)
      global_irq_enable_i = 1'b0;
      repeat (2) @(negedge mclk_i);
      `CHK("gated irq", 1'b0, decoder_irq_o)
      global_irq_enable_i = 1'b1;
      decoder_irq_enable_i = 1'b0;
      repeat (2) @(negedge mclk_i);
      `CHK("decoder gated irq", 1'b0, decoder_irq_o)
      decoder_irq_enable_i = 1'b1;
      chk_reg(8'hC8, 8'h38, 8'h20 >> k);
      repeat (2) @(negedge mclk_i);
      `CHK("cleared irq", 1'b0, decoder_irq_o)
    end
    $display("test errors and interrupt done");
    i_dec.header(1'b0, audio_dec_regs_pkg::RATE_CODE_C);
    chk_reg(8'hC8, 8'h07, {5'h00, audio_dec_regs_pkg::RATE_CODE_C, 1'b0});
    i_dec.header(1'b1, audio_dec_regs_pkg::RATE_CODE_B);
    chk_reg(8'hC8, 8'h07, {5'h00, audio_dec_regs_pkg::RATE_CODE_B, 1'b1});
    i_dec.header(1'b0, audio_dec_regs_pkg::RATE_CODE_A);
    chk_reg(8'hC8, 8'h07, {5'h00, audio_dec_regs_pkg::RATE_CODE_A, 1'b0});
    i_dec.push_aux(8'hA5);
    i_dec.push_aux(8'h5A);
    chk_reg(8'hC8, 8'h80, 8'h80);
    chk_reg(8'hAD, 8'hFF, 8'hA5);
    chk_reg(8'hC8, 8'h80, 8'h80);
    chk_reg(8'hAD, 8'hFF, 8'h5A);
    chk_reg(8'hC8, 8'h80, 8'h00);
    $display("test header and aux done");
    sfr_write(8'hAA, 8'hC0);
    `CHK("control outs", 3'b110, {decoder_on_o, low_boost_on_o, play_bad_checksum_o})
    chk_reg(8'hAA, 8'hFF, 8'hC0);
    sfr_write(8'hAA, 8'h00);
    `CHK("decoder off", 1'b0, decoder_on_o)
    sfr_write(8'hAA, 8'h80);
    repeat (3) @(negedge mclk_i);
    `CHK("first fill", 1'b1, first_fill_o)
    chk_reg(8'hAF, 8'hFF, 8'h18);
    chk_reg(8'hC8, 8'h40, 8'h40);
    chk_reg(8'hC8, 8'h40, 8'h00);
    for (int n = 0; n < FILL; n++)
    begin
      if (n == FILL - 1)
        chk_reg(8'hAF, 8'h18, 8'h18);
      sfr_write(8'hAC, 8'h30 + n[7:0]);
      `CHK("stream byte", 8'h30 + n[7:0], stream_byte_o)
      `CHK("stream valid", 1'b1, stream_valid_o)
    end
    repeat (2) @(negedge mclk_i);
    `CHK("first fill end", 1'b0, first_fill_o)
    chk_reg(8'hAF, 8'hFF, 8'h00);
    i_dec.pulse_err(2);
    `CHK("frame skip", 1'b1, frame_skip_o)
    sfr_write(8'hAA, 8'hA0);
    i_dec.pulse_err(2);
    `CHK("frame kept", 1'b0, frame_skip_o)
    i_dec.set_need(1'b1);
    repeat (3) @(negedge mclk_i);
    chk_reg(8'hAF, 8'hFF, 8'h18);
    chk_reg(8'hC8, 8'h48, 8'h48);
    chk_reg(8'hC8, 8'h48, 8'h00);
    i_dec.set_need(1'b0);
    repeat (3) @(negedge mclk_i);
    chk_reg(8'hAF, 8'h10, 8'h00);
    $display("test fill and request done");
    results();
  end
endmodule : audio_dec_regs_test
